// ===== verif/rlstat_props.sv
// Concurrent checks on the ports of the reference and loop status bank.
`timescale 1ns/100ps
`default_nettype none
module rlstat_props
  import rlstat_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [4:0]  ref_precise_fail,
  input wire logic [4:0]  ref_soak_fail,
  input wire logic [4:0]  ref_coarse_fail,
  input wire logic [4:0]  ref_cycle_fail,
  input wire logic [4:0]  ref_signal_lost,
  input wire logic        loop0_slope_hit,
  input wire logic        loop0_phmem_hit,
  input wire logic        loop0_range_hit,
  input wire logic        holdover_active,
  input wire logic        loop0_locked
);
  wire logic       rd = psel && penable && !pwrite;
  wire logic [9:0] ix = paddr[11:2];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_precise_bit: assert property (rd && ix == IDX_REF_FLAGS_5
    |-> prdata[4] == $past(ref_precise_fail[0], 3)) else $error("precise flag wrong");
  a_soak_bit: assert property (rd && ix == IDX_REF_FLAGS_6
    |-> prdata[3] == $past(ref_soak_fail[1], 3)) else $error("soak flag wrong");
  a_coarse_bit: assert property (rd && ix == IDX_REF_FLAGS_7
    |-> prdata[2] == $past(ref_coarse_fail[2], 3)) else $error("coarse flag wrong");
  a_cycle_bit: assert property (rd && ix == IDX_REF_FLAGS_8
    |-> prdata[1] == $past(ref_cycle_fail[3], 3)) else $error("cycle flag wrong");
  a_signal_bit: assert property (rd && ix == IDX_REF_FLAGS_9
    |-> prdata[0] == $past(ref_signal_lost[4], 3)) else $error("signal flag wrong");
  a_limit_bits: assert property (rd && ix == IDX_LOOP0_HEALTH
    |-> prdata[7:5] == $past({loop0_slope_hit, loop0_phmem_hit, loop0_range_hit}, 3))
    else $error("limit bits wrong");
  a_lock_bits: assert property (rd && ix == IDX_LOOP0_HEALTH
    |-> prdata[4:0] == {3'h0, $past({holdover_active, !loop0_locked}, 3)})
    else $error("lock bits wrong");
  a_ref_reserved: assert property (rd && ix >= IDX_REF_FLAGS_5 && ix <= IDX_REF_FLAGS_9
    |-> prdata[31:5] == 27'h0) else $error("reserved bits set");
endmodule
bind rlstat_bank rlstat_props u_props (.*);
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the reference and loop status bank.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import rlstat_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [29:0] st = 30'h0200_0000;
  int          miscompares = 0, checks = 0, i, n;
  logic [47:0] rows [10] = '{{30'h0010_0000, 10'h10b, 8'h10}, {30'h0001_0000, 10'h10c, 8'h08},
    {30'h0000_1000, 10'h10d, 8'h04}, {30'h0000_0100, 10'h10e, 8'h02},
    {30'h0000_0010, 10'h10f, 8'h01}, {30'h3fff_ffff, 10'h10b, 8'h1f},
    {30'h2000_0000, 10'h116, 8'h81}, {30'h1200_0000, 10'h116, 8'h40},
    {30'h0e00_0000, 10'h116, 8'h22}, {30'h0200_0000, 10'h116, 8'h00}};
  always #20 pclk = ~pclk;
  rlstat_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_precise_fail(st[24:20]), .ref_soak_fail(st[19:15]),
    .ref_coarse_fail(st[14:10]), .ref_cycle_fail(st[9:5]), .ref_signal_lost(st[4:0]),
    .loop0_slope_hit(st[29]), .loop0_phmem_hit(st[28]), .loop0_range_hit(st[27]),
    .holdover_active(st[26]), .loop0_locked(st[25]), .irq(irq));
  task automatic summarize;
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (pready === 1'h1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n == 50)
    begin
      $display("CHECK FAILED %0t no pready", $time);
      miscompares++;
      summarize();
    end
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    for (i = 0; i < 6; i++)
    begin
      apb(1'h0, i < 5 ? 12'h42c + 12'(4 * i) : ADDR_LOOP0_HEALTH, 32'h0);
      chk(rd, 32'h0);
    end
    for (i = 0; i < 10; i++)
    begin
      st <= rows[i][47:18];
      repeat (3) @(posedge pclk);
      apb(1'h0, {rows[i][17:8], 2'h0}, 32'h0);
      chk(rd, {24'h0, rows[i][7:0]});
    end
    st <= 30'h0210_0000;
    apb(1'h1, ADDR_REF_FLAGS_5, 32'hff);
    chk({31'h0, err}, 32'h0);
    apb(1'h0, ADDR_REF_FLAGS_5, 32'h0);
    chk(rd, 32'h10);
    apb(1'h0, 12'h400, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'h1, ADDR_IRQ_STATUS, 32'h3fff_ffff);
    st <= 30'h0210_0001;
    repeat (4) @(posedge pclk);
    apb(1'h0, ADDR_IRQ_STATUS, 32'h0);
    chk({rd[30:0], irq}, 32'h2);
    apb(1'h1, ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire

// ===== verilog/rlstat_bank.sv
// APB register bank reporting reference monitor flags 5 to 9 and loop 0 health.
`timescale 1ns/100ps
`default_nettype none

module rlstat_bank
  import rlstat_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  ref_precise_fail,
  input  wire logic [4:0]  ref_soak_fail,
  input  wire logic [4:0]  ref_coarse_fail,
  input  wire logic [4:0]  ref_cycle_fail,
  input  wire logic [4:0]  ref_signal_lost,
  input  wire logic        loop0_slope_hit,
  input  wire logic        loop0_phmem_hit,
  input  wire logic        loop0_range_hit,
  input  wire logic        holdover_active,
  input  wire logic        loop0_locked,
  output logic             irq
);

  // Monitor inputs come from other logic and pass two flip-flops first.
  logic [IRQ_W-1:0] raw_vec;
  logic [IRQ_W-1:0] sync_a;
  logic [IRQ_W-1:0] sync_b;
  logic [IRQ_W-1:0] prev_b;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  assign raw_vec = {loop0_slope_hit, loop0_phmem_hit, loop0_range_hit, holdover_active,
                    ~loop0_locked, ref_precise_fail, ref_soak_fail, ref_coarse_fail,
                    ref_cycle_fail, ref_signal_lost};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= '0;
      sync_b <= '0;
      prev_b <= '0;
    end
    else
    begin
      sync_a <= raw_vec;
      sync_b <= sync_a;
      prev_b <= sync_b;
    end
  end

  // Per-reference flag bytes; upper bits are reserved and read zero.
  logic [7:0] ref_byte [NUM_REFS];
  genvar g;
  generate
    for (g = 0; g < NUM_REFS; g++)
    begin : gen_ref
      always_comb
      begin
        ref_byte[g]          = REG_RESET;
        ref_byte[g][BIT_PRECISE_FAIL] = sync_b[4*NUM_REFS + g];
        ref_byte[g][BIT_SOAK_FAIL]    = sync_b[3*NUM_REFS + g];
        ref_byte[g][BIT_COARSE_FAIL]  = sync_b[2*NUM_REFS + g];
        ref_byte[g][BIT_CYCLE_FAIL]   = sync_b[NUM_REFS + g];
        ref_byte[g][BIT_SIGNAL_LOST]  = sync_b[g];
      end
    end
  endgenerate

  localparam int unsigned LB = REF_FLAG_W * NUM_REFS;
  logic [7:0] loop_byte;
  always_comb
  begin
    loop_byte                = REG_RESET;
    loop_byte[BIT_SLOPE_HIT] = sync_b[LB + 4];
    loop_byte[BIT_PHMEM_HIT] = sync_b[LB + 3];
    loop_byte[BIT_RANGE_HIT] = sync_b[LB + 2];
    loop_byte[BIT_HOLDOVER]  = sync_b[LB + 1];
    loop_byte[BIT_LOCK_LOST] = sync_b[LB];
  end

  // Address decode.
  wire        access      = psel & penable;
  wire [9:0]  idx         = paddr[11:2];
  wire [9:0]  ref_off     = idx - IDX_REF_FLAGS_5;
  wire        hit_ref     = (idx >= IDX_REF_FLAGS_5) && (idx <= IDX_REF_FLAGS_9);
  wire        hit_loop    = (idx == IDX_LOOP0_HEALTH);
  wire        hit_status  = (idx == IDX_IRQ_STATUS);
  wire        hit_mask    = (idx == IDX_IRQ_MASK);
  wire        mapped      = hit_ref | hit_loop | hit_status | hit_mask;
  wire        wr_status   = access & pwrite & hit_status;
  wire        wr_mask     = access & pwrite & hit_mask;
  wire [2:0]  ref_sel     = ref_off[2:0];
  wire [7:0]  sel_ref     = hit_ref ? ref_byte[ref_sel] : 8'h00;

  logic [31:0] next_prdata;
  assign next_prdata = hit_loop   ? {24'h000000, loop_byte} :
                       hit_ref    ? {24'h000000, sel_ref} :
                       hit_status ? {{(32-IRQ_W){1'b0}}, irq_status} :
                       hit_mask   ? {{(32-IRQ_W){1'b0}}, irq_mask} : 32'h00000000;

  // Zero-wait slave; read data is captured at the setup edge so that it comes from a flop
  // throughout the access cycle. Writes to status bytes are dropped, unmapped access errors.
  wire        rd_setup    = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Rising flag edges set sticky bits; a new event beats a write-one clear.
  wire [IRQ_W-1:0] rise = sync_b & ~prev_b;
  logic [IRQ_W-1:0] next_irq_status;
  assign next_irq_status = (irq_status & ~(wr_status ? pwdata[IRQ_W-1:0] : '0)) | rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= '0;
      irq_mask   <= '0;
      irq        <= 1'b0;
      prdata     <= 32'h00000000;
    end
    else
    begin
      irq_status <= next_irq_status;
      if (wr_mask)
        irq_mask <= pwdata[IRQ_W-1:0];
      irq        <= |(next_irq_status & (wr_mask ? pwdata[IRQ_W-1:0] : irq_mask));
      prdata     <= rd_setup ? next_prdata : 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// ===== verilog/rlstat_pkg.sv
// Package with register map, field layout and reset values for the reference and loop status bank.
package rlstat_pkg;

  localparam int unsigned NUM_REFS      = 5;
  localparam int unsigned FIRST_REF     = 5;

  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_REF_FLAGS_5   = 10'h10b;
  localparam logic [9:0] IDX_REF_FLAGS_6   = 10'h10c;
  localparam logic [9:0] IDX_REF_FLAGS_7   = 10'h10d;
  localparam logic [9:0] IDX_REF_FLAGS_8   = 10'h10e;
  localparam logic [9:0] IDX_REF_FLAGS_9   = 10'h10f;
  localparam logic [9:0] IDX_LOOP0_HEALTH  = 10'h116;
  localparam logic [9:0] IDX_IRQ_STATUS    = 10'h1f0;
  localparam logic [9:0] IDX_IRQ_MASK      = 10'h1f1;

  localparam logic [11:0] ADDR_REF_FLAGS_5  = {IDX_REF_FLAGS_5, 2'h0};
  localparam logic [11:0] ADDR_LOOP0_HEALTH = {IDX_LOOP0_HEALTH, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS   = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK     = {IDX_IRQ_MASK, 2'h0};

  // Reference monitor flag positions.
  localparam int unsigned BIT_SIGNAL_LOST  = 0;
  localparam int unsigned BIT_CYCLE_FAIL   = 1;
  localparam int unsigned BIT_COARSE_FAIL  = 2;
  localparam int unsigned BIT_SOAK_FAIL    = 3;
  localparam int unsigned BIT_PRECISE_FAIL = 4;
  localparam int unsigned REF_FLAG_W = 5;

  // Loop 0 health positions.
  localparam int unsigned BIT_LOCK_LOST    = 0;
  localparam int unsigned BIT_HOLDOVER     = 1;
  localparam int unsigned BIT_RANGE_HIT    = 5;
  localparam int unsigned BIT_PHMEM_HIT    = 6;
  localparam int unsigned BIT_SLOPE_HIT    = 7;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int unsigned IRQ_W    = NUM_REFS * REF_FLAG_W + 5;

endpackage
